/* rtl/sadc_defs.vh */
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef SADC_DEFS_VH
`define SADC_DEFS_VH

// --------------------------------------------------------------
// register offsets
// --------------------------------------------------------------
`define SADC_ADDR_MISC_MASK 8'h92
`define SADC_ADDR_P1_MASK 8'h96
`define SADC_ADDR_TRIM 8'hbb
`define SADC_ADDR_CFG 8'hc3
`define SADC_ADDR_CTRL 8'hc4
`define SADC_ADDR_RES_LOW 8'hc5
`define SADC_ADDR_RES_HIGH 8'hc6

// --------------------------------------------------------------
// converter_control fields
// --------------------------------------------------------------
`define SADC_CTRL_ON 7
`define SADC_CTRL_CHS3 5
`define SADC_CTRL_DONE 4
`define SADC_CTRL_GO 3
`define SADC_CTRL_CHS_HI 2
`define SADC_CTRL_CHS_LO 0

// --------------------------------------------------------------
// converter_config and offset_trim_config fields
// --------------------------------------------------------------
`define SADC_CFG_CLK_HI 7
`define SADC_CFG_CLK_LO 5
`define SADC_CFG_RALIGN 4
`define SADC_CFG_TRIG_HI 1
`define SADC_CFG_TRIG_LO 0
`define SADC_TRIM_HI 4
`define SADC_TRIM_LO 0

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define SADC_RST_BYTE 8'h00
`define SADC_RST_TRIM 5'h00
`define SADC_RST_RESULT 10'h000

// --------------------------------------------------------------
// trigger modes and clock codes
// --------------------------------------------------------------
`define SADC_TRIG_SOFT 2'h0
`define SADC_TRIG_TIMER0 2'h1
`define SADC_TRIG_FREE 2'h2
`define SADC_TRIG_UART3 2'h3
`define SADC_CLK_UART3 3'h6
`define SADC_CLK_TIMER4 3'h7

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define SADC_CONV_CLOCKS 5'h1e
`define SADC_RES_MAX 11'sh3ff

`endif

/* rtl/sadc_top.v */
// control logic of the ten-bit successive-approximation converter
//
// What this block does
// - a conversion lasts exactly thirty conversion-clock ticks, start to stored result and flag.
// - converter_on clear powers the converter off; set powers it up.
// - completion sets convert_done_flag, requests interrupt if enabled; software clears by writing zero.
// - writing one to convert_go starts; zero does nothing; completion sets flag, and clears go in software trigger mode only.
// - start requests are ignored while convert_go or convert_done_flag is high.
// - four-bit input_select picks port1 pins 0-7, port5 pins 0-6, port2 pin 0.
// - conv_clock_select gives clock divided 1..32, or uart3 or timer4 overflow halved.
// - left alignment puts bits 9-2 in result_high, bits 1-0 in result_low 7-6.
// - right alignment puts bits 9-8 in result_high 1-0, bits 7-0 in result_low.
// - result bits unused by the chosen alignment read as zero.
// - result is an unsigned ten-bit code, zero at bottom of range.
// - trigger_source_select picks software, timer0 overflow, free running or uart3 overflow.
// - five-bit two's-complement offset_trim is added to each raw result before storing.
// - a set analog_only_mask bit disables that pin's digital input and reads zero.
// - conversions finish during idle and may wake the cpu; power-down stops the converter.
// - hardware trigger modes keep converting until disabled, or until the next completion after software mode is selected.
// - at completion both result registers, flag set and (in software mode) go clear change together.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`include "sadc_defs.vh"

module sadc_top (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire done_irq_enable,
  input wire idle_mode,
  input wire power_down_mode,
  input wire timer0_overflow,
  input wire uart3_rate_overflow,
  input wire timer4_overflow,
  output wire done_irq_request,
  output wire cpu_wake_request,
  output wire converter_power,
  output reg [3:0] sar_channel,
  output reg sar_sample,
  output wire sar_clk_tick,
  input wire [9:0] sar_result,
  input wire [7:0] port1_pins,
  input wire [7:0] misc_pins,
  output wire [7:0] port1_din_enable,
  output wire [7:0] misc_din_enable,
  output reg [7:0] port1_pin_value,
  output reg [7:0] misc_pin_value
);

  // --------------------------------------------------------------
  // states
  // --------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // --------------------------------------------------------------
  // functions
  // --------------------------------------------------------------

  // mask of divider bits that must all be one for a tick
  function [4:0] div_mask;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: div_mask = 5'h00;
        3'h1: div_mask = 5'h01;
        3'h2: div_mask = 5'h03;
        3'h3: div_mask = 5'h07;
        3'h4: div_mask = 5'h0f;
        default: div_mask = 5'h1f;
      endcase
    end
  endfunction

  // raw code plus signed trim, clamped to the ten-bit range
  function [9:0] trim_sat;
    input [9:0] raw;
    input [4:0] trim;
    reg signed [11:0] sum;
    begin
      sum = $signed({2'b00, raw}) + $signed({{7{trim[4]}}, trim});
      if (sum < 12'sd0) begin
        trim_sat = 10'h000;
      end else if (sum > 12'sd1023) begin
        trim_sat = 10'h3ff;
      end else begin
        trim_sat = sum[9:0];
      end
    end
  endfunction

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg [1:0] state;
  reg converter_on;
  reg [3:0] input_select;
  reg convert_done_flag;
  reg convert_go;
  reg [2:0] conv_clock_select;
  reg right_align_select;
  reg [1:0] trigger_source_select;
  reg [4:0] offset_trim;
  reg [7:0] port1_analog_only_mask;
  reg [7:0] port_misc_analog_only_mask;
  reg [7:0] result_high;
  reg [7:0] result_low;
  reg [2:0] cur_clock_select;
  reg [4:0] div_cnt;
  reg ovf_half;
  reg [4:0] tick_cnt;

  wire wr_ctrl;
  wire active;
  wire trig_hit;
  wire conv_tick;
  wire conv_last;
  wire start_conv;
  wire ovf_sel;
  wire [9:0] stored;
  reg [7:0] next_rdata;

  // --------------------------------------------------------------
  // decode and combinational control
  // --------------------------------------------------------------

  assign wr_ctrl = reg_wr && (reg_addr == `SADC_ADDR_CTRL);

  // power-down freezes the sequence; idle does not
  assign active = converter_on && !power_down_mode;
  assign converter_power = converter_on;

  // trigger source decides when a pending go turns into a start
  assign trig_hit = (trigger_source_select == `SADC_TRIG_SOFT) ? 1'b1 :
                    (trigger_source_select == `SADC_TRIG_TIMER0) ? timer0_overflow :
                    (trigger_source_select == `SADC_TRIG_FREE) ? 1'b1 :
                    uart3_rate_overflow;

  assign start_conv = (state == ST_IDLE) && convert_go && active && trig_hit;

  // overflow-derived clocks tick on every second overflow
  assign ovf_sel = (cur_clock_select == `SADC_CLK_UART3) ? uart3_rate_overflow : timer4_overflow;
  // gated by clk_en so the core never counts a tick while the sequence is frozen
  assign conv_tick = clk_en && (state == ST_CONV) && active &&
                     ((cur_clock_select < `SADC_CLK_UART3) ?
                      ((div_cnt & div_mask(cur_clock_select)) == div_mask(cur_clock_select)) :
                      (ovf_sel && ovf_half));
  assign conv_last = conv_tick && (tick_cnt == (`SADC_CONV_CLOCKS - 5'h01));
  assign sar_clk_tick = conv_tick;

  assign stored = trim_sat(sar_result, offset_trim);

  // the flag requests an interrupt when done_irq_enable is set and, in idle, wakes the cpu
  assign done_irq_request = convert_done_flag && done_irq_enable;
  assign cpu_wake_request = done_irq_request && idle_mode;

  // masked pins lose their digital input path
  assign port1_din_enable = ~port1_analog_only_mask;
  assign misc_din_enable = ~port_misc_analog_only_mask;

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------

  // reserved bits are simply not stored, so they never steer anything
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_clock_select <= 3'h0;
      right_align_select <= 1'b0;
      trigger_source_select <= `SADC_TRIG_SOFT;
      offset_trim <= `SADC_RST_TRIM;
      port1_analog_only_mask <= `SADC_RST_BYTE;
      port_misc_analog_only_mask <= `SADC_RST_BYTE;
      converter_on <= 1'b0;
      input_select <= 4'h0;
    end else if (clk_en) begin
      if (reg_wr && (reg_addr == `SADC_ADDR_CFG)) begin
        conv_clock_select <= reg_wdata[`SADC_CFG_CLK_HI:`SADC_CFG_CLK_LO];
        right_align_select <= reg_wdata[`SADC_CFG_RALIGN];
        trigger_source_select <= reg_wdata[`SADC_CFG_TRIG_HI:`SADC_CFG_TRIG_LO];
      end
      if (reg_wr && (reg_addr == `SADC_ADDR_TRIM)) begin
        offset_trim <= reg_wdata[`SADC_TRIM_HI:`SADC_TRIM_LO];
      end
      if (reg_wr && (reg_addr == `SADC_ADDR_P1_MASK)) begin
        port1_analog_only_mask <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `SADC_ADDR_MISC_MASK)) begin
        port_misc_analog_only_mask <= reg_wdata;
      end
      if (wr_ctrl) begin
        converter_on <= reg_wdata[`SADC_CTRL_ON];
        input_select <= {reg_wdata[`SADC_CTRL_CHS3], reg_wdata[`SADC_CTRL_CHS_HI:`SADC_CTRL_CHS_LO]};
      end
    end
  end

  // --------------------------------------------------------------
  // go and done flags
  // --------------------------------------------------------------

  // completion sets the flag even in the cycle software clears it
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      convert_done_flag <= 1'b0;
      convert_go <= 1'b0;
    end else if (clk_en) begin
      if (conv_last) begin
        convert_done_flag <= 1'b1;
      end else if (wr_ctrl && !reg_wdata[`SADC_CTRL_DONE]) begin
        convert_done_flag <= 1'b0;
      end
      if (!converter_on || (wr_ctrl && !reg_wdata[`SADC_CTRL_ON])) begin
        convert_go <= 1'b0;
      end else if (conv_last && (trigger_source_select == `SADC_TRIG_SOFT)) begin
        convert_go <= 1'b0;
      end else if ((state == ST_IDLE) && (trigger_source_select == `SADC_TRIG_SOFT) && convert_go) begin
        convert_go <= convert_go;
      end else if (wr_ctrl && reg_wdata[`SADC_CTRL_GO] && !convert_go && !convert_done_flag) begin
        convert_go <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------
  // conversion sequencer
  // --------------------------------------------------------------

  // divider restarts at each start so every conversion is exactly thirty ticks long
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      div_cnt <= 5'h00;
      ovf_half <= 1'b0;
      tick_cnt <= 5'h00;
      cur_clock_select <= 3'h0;
      sar_channel <= 4'h0;
      sar_sample <= 1'b0;
    end else if (clk_en) begin
      sar_sample <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start_conv) begin
            state <= ST_CONV;
            div_cnt <= 5'h00;
            ovf_half <= 1'b0;
            tick_cnt <= 5'h00;
            cur_clock_select <= conv_clock_select;
            sar_channel <= input_select;
            sar_sample <= 1'b1;
          end
        end
        ST_CONV: begin
          if (!converter_on) begin
            state <= ST_IDLE;
          end else if (active) begin
            div_cnt <= div_cnt + 5'h01;
            if ((cur_clock_select >= `SADC_CLK_UART3) && ovf_sel) begin
              ovf_half <= !ovf_half;
            end
            if (conv_last) begin
              state <= ST_IDLE;
            end else if (conv_tick) begin
              tick_cnt <= tick_cnt + 5'h01;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // result registers
  // --------------------------------------------------------------

  // both bytes load in the completion cycle, unused bits forced to zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      result_high <= `SADC_RST_BYTE;
      result_low <= `SADC_RST_BYTE;
    end else if (clk_en && conv_last) begin
      if (right_align_select) begin
        result_high <= {6'h00, stored[9:8]};
        result_low <= stored[7:0];
      end else begin
        result_high <= stored[9:2];
        result_low <= {stored[1:0], 6'h00};
      end
    end
  end

  // --------------------------------------------------------------
  // port input values
  // --------------------------------------------------------------

  // masked pins read as zero in their port input register
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      port1_pin_value <= 8'h00;
      misc_pin_value <= 8'h00;
    end else if (clk_en) begin
      port1_pin_value <= port1_pins & ~port1_analog_only_mask;
      misc_pin_value <= misc_pins & ~port_misc_analog_only_mask;
    end
  end

  // --------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------

  // read mux; reserved and unmapped positions return zero
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `SADC_ADDR_CTRL: begin
        next_rdata = {converter_on, 1'b0, input_select[3], convert_done_flag,
                      convert_go, input_select[2:0]};
      end
      `SADC_ADDR_CFG: begin
        next_rdata = {conv_clock_select, right_align_select, 2'b00, trigger_source_select};
      end
      `SADC_ADDR_TRIM: begin
        next_rdata = {3'b000, offset_trim};
      end
      `SADC_ADDR_RES_LOW: begin
        next_rdata = result_low;
      end
      `SADC_ADDR_RES_HIGH: begin
        next_rdata = result_high;
      end
      `SADC_ADDR_P1_MASK: begin
        next_rdata = port1_analog_only_mask;
      end
      `SADC_ADDR_MISC_MASK: begin
        next_rdata = port_misc_analog_only_mask;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

endmodule

/* test/sadc_sar_model.sv */
// behavioural multiplexer and converter core facing the control block
`timescale 1ns/1ps
module sadc_sar_model (
  input wire clk,
  input wire reset,
  input wire converter_power,
  input wire sar_sample,
  input wire sar_clk_tick,
  input wire [9:0] code_in,
  output logic [9:0] sar_result
);
  logic [9:0] held;
  logic [5:0] ticks;
  logic active;
  // hold the code from the sample until the 30th tick; count ticks to know when it lapses
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      held <= 10'h000;
      ticks <= 6'h00;
      active <= 1'b0;
    end else if (sar_sample) begin
      held <= code_in;
      ticks <= {5'h00, sar_clk_tick};
      active <= 1'b1;
    end else if (sar_clk_tick) begin
      ticks <= ticks + 6'h01;
    end
  end
  // outside the valid span show the inverse so a late or early capture is caught
  assign sar_result = (active && converter_power && ticks <= 6'h1d) ? held : ~held;
endmodule

/* test/sadc_top_checker.sv */
// concurrent checks on the converter control ports
`timescale 1ns/1ps
module sadc_top_checker (
  input wire clk,
  input wire reset,
  input wire clk_en,
  input wire idle_mode,
  input wire power_down_mode,
  input wire done_irq_enable,
  input wire done_irq_request,
  input wire cpu_wake_request,
  input wire converter_power,
  input wire [3:0] sar_channel,
  input wire sar_sample,
  input wire sar_clk_tick,
  input wire [7:0] port1_pins,
  input wire [7:0] misc_pins,
  input wire [7:0] port1_din_enable,
  input wire [7:0] misc_din_enable,
  input wire [7:0] port1_pin_value,
  input wire [7:0] misc_pin_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [5:0] tick_cnt;
  // ticks since the last start; cleared on power loss so an aborted run does not carry over
  always @(posedge clk or posedge reset) begin
    if (reset) tick_cnt <= 6'h00;
    else if (!converter_power) tick_cnt <= 6'h00;
    else if (clk_en && sar_sample) tick_cnt <= {5'h00, sar_clk_tick};
    else if (clk_en && sar_clk_tick) tick_cnt <= tick_cnt + 6'h01;
  end
  tick_count_limit_a: assert property (tick_cnt <= 6'h1e) else $error("more than 30 ticks");
  start_when_free_a: assert property (sar_sample |-> (tick_cnt == 6'h00 || tick_cnt == 6'h1e))
    else $error("start inside a running conversion");
  sample_one_cycle_a: assert property (sar_sample && clk_en |=> !sar_sample) else $error("sample too long");
  channel_held_a: assert property ((tick_cnt != 6'h00 && tick_cnt < 6'h1e && !sar_sample)
    |-> $stable(sar_channel)) else $error("channel moved mid conversion");
  power_off_quiet_a: assert property (!converter_power |-> !sar_clk_tick && !sar_sample)
    else $error("activity while powered off");
  power_down_freeze_a: assert property (power_down_mode |-> !sar_clk_tick) else $error("tick in power-down");
  irq_gated_a: assert property (done_irq_request |-> done_irq_enable) else $error("irq without enable");
  wake_from_idle_a: assert property (cpu_wake_request == (done_irq_request && idle_mode))
    else $error("wake request wrong");
  port1_mask_a: assert property ($past(clk_en) && !$past(reset)
    |-> port1_pin_value == $past(port1_pins & port1_din_enable)) else $error("port1 pin value wrong");
  misc_mask_a: assert property ($past(clk_en) && !$past(reset)
    |-> misc_pin_value == $past(misc_pins & misc_din_enable)) else $error("misc pin value wrong");
  cover property (sar_sample);
  cover property (tick_cnt == 6'h1e);
  cover property (cpu_wake_request);
endmodule
bind sadc_top sadc_top_checker chk_u (.clk, .reset, .clk_en, .idle_mode, .power_down_mode, .done_irq_enable,
  .done_irq_request, .cpu_wake_request, .converter_power, .sar_channel, .sar_sample, .sar_clk_tick,
  .port1_pins, .misc_pins, .port1_din_enable, .misc_din_enable, .port1_pin_value, .misc_pin_value);

/* test/test_sar_adc_control.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "sadc_defs.vh"
module test_sar_adc_control;
  logic clk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, done_irq_enable = 1, idle_mode = 0;
  logic power_down_mode = 0, timer0_overflow = 0, uart3_rate_overflow = 0, timer4_overflow = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, port1_pins = 8'ha5, misc_pins = 8'h3c;
  logic [9:0] code_in = 0;
  logic [15:0] exp;
  wire [7:0] reg_rdata, port1_din_enable, misc_din_enable, port1_pin_value, misc_pin_value;
  wire done_irq_request, cpu_wake_request, converter_power, sar_sample, sar_clk_tick;
  wire [3:0] sar_channel;
  wire [9:0] sar_result;
  int err_total = 0, checks_done = 0, cyc = 0, ticks = 0, starts = 0, n, s;
  logic [3:0] chs [6] = '{4'h3, 4'hf, 4'h0, 4'h5, 4'h9, 4'he};
  logic [2:0] cks [6] = '{3'h0, 3'h2, 3'h5, 3'h3, 3'h6, 3'h7};
  logic [4:0] trims [6] = '{5'h05, 5'h01, 5'h10, 5'h1f, 5'h0f, 5'h00};
  logic [9:0] codes [6] = '{10'h155, 10'h3ff, 10'h00a, 10'h000, 10'h200, 10'h2aa};

  sadc_top dut_u (.clk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .done_irq_enable,
    .idle_mode, .power_down_mode, .timer0_overflow, .uart3_rate_overflow, .timer4_overflow, .done_irq_request,
    .cpu_wake_request, .converter_power, .sar_channel, .sar_sample, .sar_clk_tick, .sar_result, .port1_pins,
    .misc_pins, .port1_din_enable, .misc_din_enable, .port1_pin_value, .misc_pin_value);
  sadc_sar_model sar_u (.clk, .reset, .converter_power, .sar_sample, .sar_clk_tick, .code_in, .sar_result);

  always #25 clk = ~clk;
  // overflow pulses every fourth cycle, tick and start counters, and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    {timer0_overflow, uart3_rate_overflow, timer4_overflow} <= (cyc % 4 == 0) ? 3'b111 : 3'b000;
    if (sar_sample) starts <= starts + 1;
    if (sar_sample) ticks <= int'(sar_clk_tick);
    else if (sar_clk_tick) ticks <= ticks + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] want, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    @(negedge clk);
    check(what, {8'h00, reg_rdata}, {8'h00, want});
  endtask
  task wait_done(output int cycles);
    cycles = 0;
    while (done_irq_request !== 1'b1 && cycles < 2000) begin
      @(negedge clk);
      cycles++;
    end
    // a conversion that never completes is a failure, not a silent pass
    if (cycles >= 2000) begin
      err_total++;
      tally_and_finish();
    end
  endtask
  // control byte: converter on, reserved bit zero
  function automatic logic [7:0] ctl(input logic [3:0] ch, input logic done, input logic go);
    return {1'b1, 1'b0, ch[3], done, go, ch[2:0]};
  endfunction
  // trimmed, clamped and aligned result as high:low
  function automatic logic [15:0] pack(input logic [9:0] raw, input logic [4:0] trim, input logic ra);
    int v;
    v = int'(raw) + int'($signed(trim));
    v = (v < 0) ? 0 : (v > 1023) ? 1023 : v;
    return ra ? {6'h00, v[9:0]} : {v[9:0], 6'h00};
  endfunction
  task tally_and_finish();
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset <= 0;
    rd(`SADC_ADDR_CTRL, 8'h00, "ctrl reset");
    rd(`SADC_ADDR_CFG, 8'h00, "cfg reset");
    rd(`SADC_ADDR_P1_MASK, 8'h00, "p1 mask reset");
    rd(8'h90, 8'h00, "unmapped");
    wr(`SADC_ADDR_P1_MASK, 8'h0f);
    wr(`SADC_ADDR_MISC_MASK, 8'hf0);
    rd(`SADC_ADDR_MISC_MASK, 8'hf0, "misc mask");
    check("p1 pins", port1_pin_value, 8'ha0);
    check("misc pins", misc_pin_value, 8'h0c);
    check("p1 din", port1_din_enable, 8'hf0);
    check("misc din", misc_din_enable, 8'h0f);
    wr(`SADC_ADDR_CTRL, 8'h80);
    @(negedge clk);
    check("power", converter_power, 1);
    repeat (100) @(posedge clk); // settle time before the first start
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      code_in <= codes[i];
      idle_mode <= (i == 1);
      wr(`SADC_ADDR_TRIM, {3'h0, trims[i]}); // reserved bits zero
      wr(`SADC_ADDR_CFG, {cks[i], i[0], 4'h0});
      wr(`SADC_ADDR_CTRL, ctl(chs[i], 0, 1));
      if (i == 3) begin
        repeat (10) @(posedge clk);
        power_down_mode <= 1;
        repeat (20) @(posedge clk);
        power_down_mode <= 0;
        clk_en <= 0; // frozen cycles must add no ticks
        repeat (10) @(posedge clk);
        clk_en <= 1;
      end
      wait_done(n);
      if (i == 0) check("latency", n, 32);
      check("ticks", ticks, 30);
      check("channel", sar_channel, chs[i]);
      check("wake", cpu_wake_request, i == 1);
      exp = pack(codes[i], trims[i], i[0]);
      rd(`SADC_ADDR_RES_HIGH, exp[15:8], "result high");
      rd(`SADC_ADDR_RES_LOW, exp[7:0], "result low");
      rd(`SADC_ADDR_CTRL, ctl(chs[i], 1, 0), "ctrl done");
      s = starts;
      wr(`SADC_ADDR_CTRL, ctl(chs[i], 1, 1));
      repeat (40) @(posedge clk);
      check("refused start", starts - s, 0);
      done_irq_enable <= 0;
      @(negedge clk);
      check("irq masked", done_irq_request, 0);
      @(posedge clk);
      done_irq_enable <= 1;
      wr(`SADC_ADDR_CTRL, ctl(chs[i], 0, 0));
      @(negedge clk);
      check("flag cleared", done_irq_request, 0);
    end
    for (int m = 1; m < 4; m++) begin
      wr(`SADC_ADDR_CFG, {6'h04, m[1:0]});
      wr(`SADC_ADDR_CTRL, 8'h88);
      s = starts;
      repeat (200) @(posedge clk);
      check("repeats", (starts - s) >= 3, 1);
      wr(`SADC_ADDR_CFG, 8'h10);
      repeat (80) @(posedge clk);
      rd(`SADC_ADDR_CTRL, 8'h90, "go cleared");
      wr(`SADC_ADDR_CTRL, 8'h80);
    end
    wr(`SADC_ADDR_CTRL, 8'h88);
    repeat (10) @(posedge clk);
    wr(`SADC_ADDR_CTRL, 8'h08);
    @(negedge clk);
    check("power off", converter_power, 0);
    rd(`SADC_ADDR_CTRL, 8'h00, "abort clears go");
    tally_and_finish();
  end
endmodule
